//--- shared/xdl_pkg.sv
// constants for the xor and port-direction load decoder
//------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------
package xdl_pkg;
    localparam int OPC_W = 12;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 5;
    localparam int DIR_SEL_LO = 3'h6;
    localparam int DIR_SEL_HI = 3'h7;
    localparam logic [8:0] DIR_UPPER = 9'h000;
    localparam logic [3:0] XLIT_TOP = 4'hf;
    localparam logic [5:0] XFILE_TOP = 6'h06;
    localparam int DEST_BIT = 5;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'hff;
    typedef enum {OP_NONE, OP_DIR, OP_XLIT, OP_XFILE} xdl_op_type;
endpackage

//--- rtl/xdl_core.sv
// decode and execute of the direction load and the two xor instructions
`timescale 1ns/1ps
module xdl_core (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // instruction
    input wire logic instrValid,
    input wire logic [xdl_pkg::OPC_W-1:0] opcode,
    // file register port; read is combinational from the core's file
    output logic [xdl_pkg::FADDR_W-1:0] fileAddr,
    input wire logic [xdl_pkg::DATA_W-1:0] fileRdData,
    output logic fileWrEn,
    output logic [xdl_pkg::DATA_W-1:0] fileWrData,
    // zero flag
    output logic zeroWrEn,
    output logic zeroVal,
    // architectural state
    output logic [xdl_pkg::DATA_W-1:0] accumulator,
    output logic [xdl_pkg::DATA_W-1:0] portDirB,
    output logic [xdl_pkg::DATA_W-1:0] portDirC
);
    import xdl_pkg::*;

    //------------------------------------------------------------
    // decode
    //------------------------------------------------------------
    function automatic xdl_op_type decodeOp(input logic [OPC_W-1:0] op);
        // the three encodings never overlap; the order only fixes which test runs first
        if (op[11:3] == DIR_UPPER && (op[2:0] == DIR_SEL_LO[2:0] || op[2:0] == DIR_SEL_HI[2:0]))
            return OP_DIR;
        if (op[11:8] == XLIT_TOP)
            return OP_XLIT;
        if (op[11:6] == XFILE_TOP)
            return OP_XFILE;
        return OP_NONE;
    endfunction

    // one zero test serves both xor paths, so the flag cannot drift between them
    function automatic logic isZero(input logic [DATA_W-1:0] value);
        return value == '0;
    endfunction

    xdl_op_type curOp;
    logic [DATA_W-1:0] result;
    logic destFile;
    logic [DATA_W-1:0] acc_ff, nxt_acc;
    logic [DATA_W-1:0] dirB_ff, nxt_dirB, dirC_ff, nxt_dirC;
    logic fwe_ff, nxt_fwe, zwe_ff, nxt_zwe, zv_ff, nxt_zv;
    logic [DATA_W-1:0] fwd_ff, nxt_fwd;
    logic [FADDR_W-1:0] fa_ff, nxt_fa;

    // instrValid low masks the decode, so a held opcode does nothing
    assign curOp = instrValid ? decodeOp(opcode) : OP_NONE;
    assign destFile = opcode[DEST_BIT];
    // the file answers in the same cycle, so its address cannot wait for a register
    assign fileAddr = opcode[FADDR_W-1:0];

    //------------------------------------------------------------
    // execute: everything retires at the edge ending the cycle
    //------------------------------------------------------------
    always_comb begin
        nxt_acc = acc_ff;
        nxt_dirB = dirB_ff;
        nxt_dirC = dirC_ff;
        nxt_fwe = 1'b0;
        nxt_fwd = fwd_ff;
        nxt_fa = fa_ff;
        nxt_zwe = 1'b0;
        nxt_zv = zv_ff;
        result = '0;
        case (curOp)
            OP_DIR: begin
                // no flag update on this path
                if (opcode[0]) nxt_dirC = acc_ff;
                else nxt_dirB = acc_ff;
            end
            OP_XLIT: begin
                result = acc_ff ^ opcode[7:0];
                nxt_acc = result;
                nxt_zwe = 1'b1;
                nxt_zv = isZero(result);
            end
            OP_XFILE: begin
                // the file data arrives combinationally in this same cycle
                result = acc_ff ^ fileRdData;
                nxt_zwe = 1'b1;
                nxt_zv = isZero(result);
                if (destFile) begin
                    nxt_fwe = 1'b1;
                    nxt_fwd = result;
                    // keep the address, as the opcode moves on before the write lands
                    nxt_fa = opcode[FADDR_W-1:0];
                end else begin
                    nxt_acc = result;
                end
            end
            default: begin
                result = '0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            acc_ff <= ACC_RESET;
            // direction registers come up all ones, so every pin starts as an input
            dirB_ff <= DIR_RESET;
            dirC_ff <= DIR_RESET;
            fwe_ff <= 1'b0;
            fwd_ff <= '0;
            fa_ff <= '0;
            zwe_ff <= 1'b0;
            zv_ff <= 1'b0;
        end else begin
            acc_ff <= nxt_acc;
            dirB_ff <= nxt_dirB;
            dirC_ff <= nxt_dirC;
            fwe_ff <= nxt_fwe;
            fwd_ff <= nxt_fwd;
            fa_ff <= nxt_fa;
            zwe_ff <= nxt_zwe;
            zv_ff <= nxt_zv;
        end
    end

    // file write and zero update are registered, one cycle after the opcode;
    // the core's file must hand a pending write to a read of the same register
    // in that cycle, since a following instruction would otherwise see stale data
    assign accumulator = acc_ff;
    assign portDirB = dirB_ff;
    assign portDirC = dirC_ff;
    assign fileWrEn = fwe_ff;
    assign fileWrData = fwd_ff;
    assign zeroWrEn = zwe_ff;
    assign zeroVal = zv_ff;

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    logic [FADDR_W-1:0] fileWrAddr;
    logic opDir, opLit, opFile, opFileDest;
    assign fileWrAddr = fa_ff;
    // one-bit views of the decoded operation, so the checks look back at plain signals
    assign opDir = curOp == OP_DIR;
    assign opLit = curOp == OP_XLIT;
    assign opFile = curOp == OP_XFILE;
    assign opFileDest = opFile && destFile;

    // checks are off during reset, and reset is held for at least one edge
    // the result checks look one edge past the opcode, where the registered results stand; the decode checks look at the same cycle
    a_dir_load: assert property (@(posedge clk_sys) disable iff (reset)
        opDir |=> ($past(opcode[0]) ? portDirC : portDirB) == $past(accumulator)
        && !zeroWrEn) else $error("direction load wrong");
    a_dir_other: assert property (@(posedge clk_sys) disable iff (reset)
        opDir |=> ($past(opcode[0]) ? $stable(portDirB) : $stable(portDirC))
        && $stable(accumulator) && !fileWrEn) else $error("direction load side effect");
    a_dir_refused: assert property (@(posedge clk_sys) disable iff (reset)
        instrValid && opcode[11:3] == DIR_UPPER && opcode[2:1] != 2'b11
        |=> $stable(portDirB) && $stable(portDirC) && $stable(accumulator))
        else $error("refused direction load changed state");
    // the source checks run backwards: any change must trace to its instruction
    a_dir_source: assert property (@(posedge clk_sys) disable iff (reset)
        (portDirB != $past(portDirB) || portDirC != $past(portDirC)) |-> $past(opDir))
        else $error("direction register changed without load");
    a_xlit_result: assert property (@(posedge clk_sys) disable iff (reset)
        opLit |=> accumulator == ($past(accumulator) ^ $past(opcode[7:0])))
        else $error("literal xor result wrong");
    a_xlit_flag: assert property (@(posedge clk_sys) disable iff (reset)
        opLit |=> zeroWrEn && !fileWrEn && zeroVal == (accumulator == 8'h00))
        else $error("literal xor flag wrong");
    a_xlit_dirs: assert property (@(posedge clk_sys) disable iff (reset)
        opLit |=> $stable(portDirB) && $stable(portDirC))
        else $error("literal xor touched a direction register");
    a_xlit_decode: assert property (@(posedge clk_sys) disable iff (reset)
        instrValid && opcode[11:8] == XLIT_TOP |-> opLit)
        else $error("literal xor not decoded");
    a_xfile_w: assert property (@(posedge clk_sys) disable iff (reset)
        opFile && !destFile |=> !fileWrEn
        && accumulator == ($past(accumulator) ^ $past(fileRdData)))
        else $error("file xor to acc wrong");
    a_xfile_f: assert property (@(posedge clk_sys) disable iff (reset)
        opFileDest |=> fileWrEn && $stable(accumulator)
        && fileWrData == ($past(accumulator) ^ $past(fileRdData)))
        else $error("file xor to file wrong");
    a_xfile_addr: assert property (@(posedge clk_sys) disable iff (reset)
        opFileDest |=> fileWrAddr == $past(opcode[4:0]))
        else $error("file write address wrong");
    a_xfile_decode: assert property (@(posedge clk_sys) disable iff (reset)
        instrValid && opcode[11:6] == XFILE_TOP |-> opFile)
        else $error("file xor not decoded");
    a_xfile_zero: assert property (@(posedge clk_sys) disable iff (reset)
        opFile |=> zeroWrEn
        && zeroVal == (($past(accumulator) ^ $past(fileRdData)) == 8'h00))
        else $error("file xor zero flag wrong");
    a_xfile_dirs: assert property (@(posedge clk_sys) disable iff (reset)
        opFile |=> $stable(portDirB) && $stable(portDirC))
        else $error("file xor touched a direction register");
    a_write_source: assert property (@(posedge clk_sys) disable iff (reset)
        fileWrEn |-> $past(opFileDest))
        else $error("file written without file xor");
    a_acc_source: assert property (@(posedge clk_sys) disable iff (reset)
        accumulator != $past(accumulator) |-> $past(opLit) || ($past(opFile) && !$past(destFile)))
        else $error("accumulator changed without xor to it");
    a_zero_only: assert property (@(posedge clk_sys) disable iff (reset)
        zeroWrEn |-> $past(opLit) || $past(opFile))
        else $error("zero flag touched by other op");
    a_idle_hold: assert property (@(posedge clk_sys) disable iff (reset)
        curOp == OP_NONE |=> $stable(accumulator) && !fileWrEn && !zeroWrEn)
        else $error("state changed without op");

    //------------------------------------------------------------
    // coverage of the main scenarios
    //------------------------------------------------------------
    c_dir: cover property (@(posedge clk_sys) disable iff (reset) curOp == OP_DIR);
    c_xlit_zero: cover property (@(posedge clk_sys) disable iff (reset)
        curOp == OP_XLIT ##1 zeroVal);
    c_xfile_f: cover property (@(posedge clk_sys) disable iff (reset)
        curOp == OP_XFILE && destFile);
    c_xfile_w: cover property (@(posedge clk_sys) disable iff (reset)
        curOp == OP_XFILE && !destFile);
    c_dir_hi: cover property (@(posedge clk_sys) disable iff (reset)
        opDir && opcode[0]);
endmodule

//--- tb/xor_and_direction_load_ops_test.sv
// self-checking bench for the xor and port-direction load decoder
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin mismatches++; $display("Error at %0t: value mismatch", $time); end end
module xor_and_direction_load_ops_test;
    import xdl_pkg::*;
    logic clk_sys, reset, instrValid, fileWrEn, zeroWrEn, zeroVal;
    logic [OPC_W-1:0] opcode;
    logic [FADDR_W-1:0] fileAddr, lastAddr;
    logic [DATA_W-1:0] fileWrData, accumulator, portDirB, portDirC, fileRd;
    logic [DATA_W-1:0] fileMem [32];
    int mismatches = 0;
    int total_checks = 0;
    // ------------------------------------------------------------
    // design and file register model
    // ------------------------------------------------------------
    xdl_core dut_u (.clk_sys(clk_sys), .reset(reset), .instrValid(instrValid),
        .opcode(opcode), .fileAddr(fileAddr), .fileRdData(fileRd),
        .fileWrEn(fileWrEn), .fileWrData(fileWrData), .zeroWrEn(zeroWrEn),
        .zeroVal(zeroVal), .accumulator(accumulator), .portDirB(portDirB),
        .portDirC(portDirC));
    always #2 clk_sys = ~clk_sys;
    // a pending write is handed straight to a read of the same register, as the core requires of its file
    assign fileRd = (fileWrEn === 1'b1 && lastAddr == fileAddr) ? fileWrData : fileMem[fileAddr];
    // write lands at the edge after the pulse
    always @(posedge clk_sys) begin
        lastAddr <= fileAddr;
        if (fileWrEn === 1'b1) fileMem[lastAddr] <= fileWrData;
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic run(input logic [OPC_W-1:0] op);
        @(posedge clk_sys);
        instrValid <= 1'b1;
        opcode <= op;
        @(posedge clk_sys);
        instrValid <= 1'b0;
        #1;
    endtask
    task automatic lit_xor;
        run(12'hfb5);
        `CHK(accumulator, 8'hb5)
        `CHK(zeroWrEn, 1'b1)
        `CHK(zeroVal, 1'b0)
        run(12'hfb5);
        `CHK(accumulator, 8'h00)
        `CHK(zeroVal, 1'b1)
        run(12'hfff);
        `CHK(accumulator, 8'hff)
        `CHK(fileWrEn, 1'b0)
    endtask
    task automatic dir_load;
        run(12'hf5a);
        run(12'h006);
        `CHK(portDirB, 8'ha5)
        `CHK(portDirC, DIR_RESET)
        `CHK(zeroWrEn, 1'b0)
        run(12'hfff);
        run(12'h007);
        `CHK(portDirC, 8'h5a)
        run(12'h005);
        run(12'h016);
        `CHK(portDirB, 8'ha5)
        `CHK(portDirC, 8'h5a)
    endtask
    task automatic file_xor;
        fileMem[3] = 8'haf;
        run(12'h183);
        `CHK(accumulator, 8'hf5)
        `CHK(fileWrEn, 1'b0)
        `CHK(zeroWrEn, 1'b1)
        fileMem[31] = 8'hf5;
        run(12'h1bf);
        `CHK(fileWrEn, 1'b1)
        `CHK(fileWrData, 8'h00)
        `CHK(zeroVal, 1'b1)
        `CHK(accumulator, 8'hf5)
        @(posedge clk_sys);
        #1;
        `CHK(fileMem[31], 8'h00)
    endtask
    // write of a file register directly followed by a read of the same one
    task automatic back_to_back;
        fileMem[1] = 8'h0f;
        @(posedge clk_sys);
        instrValid <= 1'b1;
        opcode <= 12'h1a1;
        @(posedge clk_sys);
        opcode <= 12'h181;
        #1;
        `CHK(fileWrEn, 1'b1)
        @(posedge clk_sys);
        instrValid <= 1'b0;
        #1;
        `CHK(accumulator, 8'h0f)
        `CHK(zeroVal, 1'b0)
    endtask
    task automatic idle_hold;
        @(posedge clk_sys);
        opcode <= 12'hfff;
        @(posedge clk_sys);
        #1;
        `CHK(accumulator, 8'h0f)
        `CHK(zeroWrEn, 1'b0)
    endtask
    // ------------------------------------------------------------
    // run control
    // ------------------------------------------------------------
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        #20000;
        mismatches++;
        conclude();
    end
    initial begin
        clk_sys = 1'b0;
        reset = 1'b1;
        instrValid = 1'b0;
        opcode = 12'h000;
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        lit_xor();
        dir_load();
        file_xor();
        back_to_back();
        idle_hold();
        conclude();
    end
endmodule
